// File: logic/iop_pkg.sv
// Types shared by the I/O port block.
// Assumes the constants header is included where offsets are needed.
package iop_pkg;
   typedef enum logic [1:0] {
      IOP_IRQ_OFF,
      IOP_IRQ_RISE,
      IOP_IRQ_FALL,
      IOP_IRQ_BOTH
   } iop_irq_type_t;

   typedef struct packed {
      logic [7:0] out_data_q;
      logic [7:0] dm0_q;
      logic [7:0] dm1_q;
      logic [7:0] dm2_q;
      logic [7:0] slew_q;
      logic [7:0] bypass_q;
      logic [7:0] bidir_q;
      logic [7:0] inp_off_q;
      logic [7:0] mask_q;
      logic [7:0] ag_q;
      logic [7:0] amux_q;
      logic [3:0] ctl_q;
      logic [7:0] lcd_role_q;
      logic [7:0] lcd_en_q;
      logic [7:0] sio_ref_q;
      logic [7:0] sio_cfg_q;
      logic [7:0] sio_hyst_q;
      logic [7:0] out_sel0_q;
      logic [7:0] out_sel1_q;
      logic [7:0] oe_sel0_q;
      logic [7:0] oe_sel1_q;
      logic [7:0] dbl_sync_q;
      logic [7:0] sync_out_q;
      logic [15:0] irq_type_q;
      logic [7:0] irq_stat_q;
      logic [7:0] snap_q;
      logic [7:0] sync1_q;
      logic [7:0] sync2_q;
      logic [7:0] pin_prev_q;
      logic        ack_q;
      logic [31:0] rdata_q;
   } iop_state_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] inp_en;
      logic [7:0] ag;
      logic [7:0] amux;
   } iop_pad_t;
endpackage

// File: logic/iop_port.sv
// One eight-pin I/O port with its pin interrupt unit, as a classic Wishbone slave.
// Assumes pin levels and logic array signals are synchronous to clk_i.
// Operation
// - Non-bypassed pin drives output data register bit.
// - Pin level register reads live pin levels.
// - Bypass bit picks data register or interconnect.
// - Bidirectional bit lets direction change dynamically.
// - Output window touches only masked bits.
// - Level window returns only masked level bits.
// - Port alias writes one bit across pins.
// - Per-pin alias exposes that pin's bits.
// - Three drive mode registers form mode code.
// - Input buffer off bit overrides drive mode.
// - Separate analog global and mux connect bits.
// - Control holds memory config and threshold.
// - LCD role and LCD pin enable per pin.
// - Two bits per pair select reference.
// - Two bits per pair configure buffers.
// - Two-bit select picks output data source.
// - Two-bit select picks output enable source.
// - Double sync puts pin through two flops.
// - Output sync registers interconnect data first.
// - Per-pin interrupt type register.
// - Status register shows posted pin interrupts.
// - Status read captures pin levels into snapshot.
// - Rising, falling or either edge only.
// - Status read clears set bits; idle pins still post.
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "iop_regs.svh"

module iop_port
   import iop_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic [7:0]  pin_i,
   input  wire logic [7:0]  dsi_out_i [4],
   input  wire logic [7:0]  dsi_oe_i [4],
   output logic      [7:0]  dsi_in_o,
   output iop_pad_t         pad_o,
   output logic      [23:0] drive_mode_o,
   output logic      [7:0]  slew_o,
   output logic      [3:0]  port_ctl_o,
   output logic      [7:0]  lcd_role_o,
   output logic      [7:0]  lcd_en_o,
   output logic      [7:0]  sio_ref_o,
   output logic      [7:0]  sio_cfg_o,
   output logic      [7:0]  sio_hyst_o,
   output logic             irq_o
);

////////////////////////////////////////////////////////////////////////////////

   iop_state_t s_q;
   iop_state_t s_d;
   logic [7:0] udb_out;
   logic [7:0] udb_oe;
   logic [7:0] in_path;
   logic [7:0] rise;
   logic [7:0] fall;
   logic [7:0] evt;
   logic       bus_req;
   logic       wr;
   logic       rd;

   assign bus_req = cyc_i && stb_i && !s_q.ack_q;
   assign wr      = bus_req && we_i && sel_i[0];
   assign rd      = bus_req && !we_i;

   genvar g;
   for (g = 0; g < 8; g++) begin : g_pin
      logic [1:0] osel;
      logic [1:0] esel;
      iop_irq_type_t ty;
      assign osel = {s_q.out_sel1_q[g], s_q.out_sel0_q[g]};
      assign esel = {s_q.oe_sel1_q[g], s_q.oe_sel0_q[g]};
      assign udb_out[g] = dsi_out_i[osel][g];
      assign udb_oe[g]  = dsi_oe_i[esel][g];
      assign ty = iop_irq_type_t'(s_q.irq_type_q[2*g +: 2]);
      assign rise[g] = pin_i[g] && !s_q.pin_prev_q[g];
      assign fall[g] = !pin_i[g] && s_q.pin_prev_q[g];
      assign evt[g] = (rise[g] && (ty == IOP_IRQ_RISE || ty == IOP_IRQ_BOTH))
                   || (fall[g] && (ty == IOP_IRQ_FALL || ty == IOP_IRQ_BOTH));
      assign pad_o.out[g] = s_q.bypass_q[g] ? (s_q.sync_out_q[g] ? s_q.out_data_q[g] : udb_out[g])
                                            : s_q.out_data_q[g];
      assign pad_o.oe[g] = s_q.bidir_q[g] ? udb_oe[g] : (s_q.dm2_q[g] | s_q.dm1_q[g]);
      assign pad_o.inp_en[g] = !s_q.inp_off_q[g]
                               && ({s_q.dm2_q[g], s_q.dm1_q[g], s_q.dm0_q[g]} != 3'h0);
      assign drive_mode_o[3*g +: 3] = {s_q.dm2_q[g], s_q.dm1_q[g], s_q.dm0_q[g]};
      assign in_path[g] = s_q.dbl_sync_q[g] ? s_q.sync2_q[g] : pin_i[g];
   end

   assign dsi_in_o     = in_path;
   assign pad_o.ag     = s_q.ag_q;
   assign pad_o.amux   = s_q.amux_q;
   assign slew_o       = s_q.slew_q;
   assign port_ctl_o   = s_q.ctl_q;
   assign lcd_role_o   = s_q.lcd_role_q;
   assign lcd_en_o     = s_q.lcd_en_q;
   assign sio_ref_o    = s_q.sio_ref_q;
   assign sio_cfg_o    = s_q.sio_cfg_q;
   assign sio_hyst_o   = s_q.sio_hyst_q;
   assign irq_o        = |s_q.irq_stat_q;
   assign ack_o        = s_q.ack_q;
   assign dat_o        = s_q.rdata_q;

////////////////////////////////////////////////////////////////////////////////

   always_comb begin
      logic [7:0] wd;
      logic [7:0] rv;
      logic [2:0] pn;
      logic [2:0] bn;
      wd = dat_i[7:0];
      rv = 8'h00;
      pn = adr_i[4:2];
      bn = dat_i[10:8];
      s_d = s_q;
      s_d.ack_q = bus_req;
      s_d.sync1_q = pin_i;
      s_d.sync2_q = s_q.sync1_q;
      s_d.pin_prev_q = pin_i;
      if (s_q.ack_q) begin
         s_d.rdata_q = 32'h0000_0000;
      end
      s_d.irq_stat_q = s_q.irq_stat_q | evt;
      if (wr) begin
         if (adr_i == `IOP_OFS_OUT_DATA) begin
            s_d.out_data_q = wd;
         end else if (adr_i == `IOP_OFS_DM0) begin
            s_d.dm0_q = wd;
         end else if (adr_i == `IOP_OFS_DM1) begin
            s_d.dm1_q = wd;
         end else if (adr_i == `IOP_OFS_DM2) begin
            s_d.dm2_q = wd;
         end else if (adr_i == `IOP_OFS_SLEW) begin
            s_d.slew_q = wd;
         end else if (adr_i == `IOP_OFS_BYPASS) begin
            s_d.bypass_q = wd;
         end else if (adr_i == `IOP_OFS_BIDIR) begin
            s_d.bidir_q = wd;
         end else if (adr_i == `IOP_OFS_INP_OFF) begin
            s_d.inp_off_q = wd;
         end else if (adr_i == `IOP_OFS_MASK) begin
            s_d.mask_q = wd;
         end else if (adr_i == `IOP_OFS_AG) begin
            s_d.ag_q = wd;
         end else if (adr_i == `IOP_OFS_AMUX) begin
            s_d.amux_q = wd;
         end else if (adr_i == `IOP_OFS_PORT_WIDE) begin
            // Bits [10:8] pick the functional register, bit [8] is copied to all pins.
            case (bn)
               3'h0: s_d.out_data_q = {8{dat_i[8]}};
               3'h1: s_d.dm0_q = {8{dat_i[8]}};
               3'h2: s_d.dm1_q = {8{dat_i[8]}};
               3'h3: s_d.dm2_q = {8{dat_i[8]}};
               3'h4: s_d.bypass_q = {8{dat_i[8]}};
               3'h5: s_d.bidir_q = {8{dat_i[8]}};
               3'h6: s_d.inp_off_q = {8{dat_i[8]}};
               default: s_d.slew_q = {8{dat_i[8]}};
            endcase
         end else if (adr_i == `IOP_OFS_CTL) begin
            s_d.ctl_q = wd[3:0];
         end else if (adr_i == `IOP_OFS_LCD_ROLE) begin
            s_d.lcd_role_q = wd;
         end else if (adr_i == `IOP_OFS_LCD_EN) begin
            s_d.lcd_en_q = wd;
         end else if (adr_i == `IOP_OFS_SIO_REF) begin
            s_d.sio_ref_q = wd;
         end else if (adr_i == `IOP_OFS_SIO_CFG) begin
            s_d.sio_cfg_q = wd;
         end else if (adr_i == `IOP_OFS_SIO_HYST) begin
            s_d.sio_hyst_q = wd;
         end else if (adr_i == `IOP_OFS_OUT_SEL0) begin
            s_d.out_sel0_q = wd;
         end else if (adr_i == `IOP_OFS_OUT_SEL1) begin
            s_d.out_sel1_q = wd;
         end else if (adr_i == `IOP_OFS_OE_SEL0) begin
            s_d.oe_sel0_q = wd;
         end else if (adr_i == `IOP_OFS_OE_SEL1) begin
            s_d.oe_sel1_q = wd;
         end else if (adr_i == `IOP_OFS_DBL_SYNC) begin
            s_d.dbl_sync_q = wd;
         end else if (adr_i == `IOP_OFS_SYNC_OUT) begin
            s_d.sync_out_q = wd;
         end else if (adr_i == `IOP_OFS_DR_WIN) begin
            s_d.out_data_q = (s_q.out_data_q & ~s_q.mask_q) | (wd & s_q.mask_q);
         end else if (adr_i[7:5] == 3'h4) begin
            // Per-pin alias: bit0 data, bits3:1 drive mode, bit4 bypass, bit5 bidir, bit6 input off.
            s_d.out_data_q[pn] = wd[0];
            s_d.dm0_q[pn] = wd[1];
            s_d.dm1_q[pn] = wd[2];
            s_d.dm2_q[pn] = wd[3];
            s_d.bypass_q[pn] = wd[4];
            s_d.bidir_q[pn] = wd[5];
            s_d.inp_off_q[pn] = wd[6];
         end else if (adr_i[7:5] == 3'h5) begin
            s_d.irq_type_q[2*pn +: 2] = wd[1:0];
         end
      end
      // Synced bypassed pins reload the data register flop from the interconnect every cycle.
      s_d.out_data_q = (s_d.out_data_q & ~(s_q.bypass_q & s_q.sync_out_q))
                     | (udb_out & s_q.bypass_q & s_q.sync_out_q);
      if (rd) begin
         if (adr_i == `IOP_OFS_OUT_DATA) begin
            rv = s_q.out_data_q;
         end else if (adr_i == `IOP_OFS_PIN_LEVEL) begin
            rv = pin_i;
         end else if (adr_i == `IOP_OFS_DM0) begin
            rv = s_q.dm0_q;
         end else if (adr_i == `IOP_OFS_DM1) begin
            rv = s_q.dm1_q;
         end else if (adr_i == `IOP_OFS_DM2) begin
            rv = s_q.dm2_q;
         end else if (adr_i == `IOP_OFS_SLEW) begin
            rv = s_q.slew_q;
         end else if (adr_i == `IOP_OFS_BYPASS) begin
            rv = s_q.bypass_q;
         end else if (adr_i == `IOP_OFS_BIDIR) begin
            rv = s_q.bidir_q;
         end else if (adr_i == `IOP_OFS_INP_OFF) begin
            rv = s_q.inp_off_q;
         end else if (adr_i == `IOP_OFS_MASK) begin
            rv = s_q.mask_q;
         end else if (adr_i == `IOP_OFS_AG) begin
            rv = s_q.ag_q;
         end else if (adr_i == `IOP_OFS_AMUX) begin
            rv = s_q.amux_q;
         end else if (adr_i == `IOP_OFS_CTL) begin
            rv = {4'h0, s_q.ctl_q};
         end else if (adr_i == `IOP_OFS_LCD_ROLE) begin
            rv = s_q.lcd_role_q;
         end else if (adr_i == `IOP_OFS_LCD_EN) begin
            rv = s_q.lcd_en_q;
         end else if (adr_i == `IOP_OFS_SIO_REF) begin
            rv = s_q.sio_ref_q;
         end else if (adr_i == `IOP_OFS_SIO_CFG) begin
            rv = s_q.sio_cfg_q;
         end else if (adr_i == `IOP_OFS_SIO_HYST) begin
            rv = s_q.sio_hyst_q;
         end else if (adr_i == `IOP_OFS_OUT_SEL0) begin
            rv = s_q.out_sel0_q;
         end else if (adr_i == `IOP_OFS_OUT_SEL1) begin
            rv = s_q.out_sel1_q;
         end else if (adr_i == `IOP_OFS_OE_SEL0) begin
            rv = s_q.oe_sel0_q;
         end else if (adr_i == `IOP_OFS_OE_SEL1) begin
            rv = s_q.oe_sel1_q;
         end else if (adr_i == `IOP_OFS_DBL_SYNC) begin
            rv = s_q.dbl_sync_q;
         end else if (adr_i == `IOP_OFS_SYNC_OUT) begin
            rv = s_q.sync_out_q;
         end else if (adr_i == `IOP_OFS_IRQ_STAT) begin
            rv = s_q.irq_stat_q;
            // Pending bits clear; their new events are blocked, idle pins still post.
            s_d.irq_stat_q = (s_q.irq_stat_q & ~s_q.irq_stat_q) | (evt & ~s_q.irq_stat_q);
            s_d.snap_q = pin_i;
         end else if (adr_i == `IOP_OFS_SNAP) begin
            rv = s_q.snap_q;
         end else if (adr_i == `IOP_OFS_DR_WIN) begin
            rv = s_q.out_data_q & s_q.mask_q;
         end else if (adr_i == `IOP_OFS_PS_WIN) begin
            rv = pin_i & s_q.mask_q;
         end else if (adr_i == `IOP_OFS_PORT_WIDE) begin
            rv = s_q.out_data_q;
         end else if (adr_i[7:5] == 3'h4) begin
            rv = {pin_i[pn], s_q.inp_off_q[pn], s_q.bidir_q[pn], s_q.bypass_q[pn],
                  s_q.dm2_q[pn], s_q.dm1_q[pn], s_q.dm0_q[pn], s_q.out_data_q[pn]};
         end else if (adr_i[7:5] == 3'h5) begin
            rv = {6'h00, s_q.irq_type_q[2*pn +: 2]};
         end
         s_d.rdata_q = {24'h00_0000, rv};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

////////////////////////////////////////////////////////////////////////////////

   chk_stat_read_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd && adr_i == `IOP_OFS_IRQ_STAT) |=> ((s_q.irq_stat_q & $past(s_q.irq_stat_q)) == 8'h00))
      else $error("Pending status bit survived its read.");

   chk_snap_capture: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd && adr_i == `IOP_OFS_IRQ_STAT) |=> (s_q.snap_q == $past(pin_i)))
      else $error("Snapshot did not capture pin levels.");

   chk_rise_posts: assert property (@(posedge clk_i) disable iff (rst_i)
      (rise[0] && s_q.irq_type_q[1:0] == 2'h1 && !rd) |=> s_q.irq_stat_q[0])
      else $error("Rising edge did not post status.");

   chk_fall_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      (fall[0] && s_q.irq_type_q[1:0] == 2'h1 && !s_q.irq_stat_q[0]) |=> !s_q.irq_stat_q[0])
      else $error("Falling edge posted on rise-only pin.");

   chk_out_source: assert property (@(posedge clk_i) disable iff (rst_i)
      !s_q.bypass_q[0] |-> pad_o.out[0] == s_q.out_data_q[0])
      else $error("Unbypassed pin not driven from data register.");

   chk_bypass_src: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_q.bypass_q[1] && !s_q.sync_out_q[1]) |-> pad_o.out[1] == udb_out[1])
      else $error("Bypassed pin not driven from interconnect.");

   chk_window_mask: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && adr_i == `IOP_OFS_DR_WIN) |=>
      ((s_q.out_data_q & ~$past(s_q.mask_q)) == ($past(s_q.out_data_q) & ~$past(s_q.mask_q))))
      else $error("Window write changed unmasked bit.");

   chk_dbl_sync: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_q.dbl_sync_q[2] && $stable(s_q.dbl_sync_q[2])) |-> dsi_in_o[2] == $past(pin_i[2], 2))
      else $error("Double sync path is not two stages.");

   chk_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("Acknowledge held beyond one cycle.");

endmodule // iop_port

// File: logic/iop_regs.svh
// Register offsets, reset values and timing counts for the I/O port block.
// Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
`ifndef IOP_REGS_SVH
`define IOP_REGS_SVH
`define IOP_OFS_OUT_DATA    8'h00
`define IOP_OFS_PIN_LEVEL   8'h04
`define IOP_OFS_DM0         8'h08
`define IOP_OFS_DM1         8'h0c
`define IOP_OFS_DM2         8'h10
`define IOP_OFS_SLEW        8'h14
`define IOP_OFS_BYPASS      8'h18
`define IOP_OFS_BIDIR       8'h1c
`define IOP_OFS_INP_OFF     8'h20
`define IOP_OFS_MASK        8'h24
`define IOP_OFS_AG          8'h28
`define IOP_OFS_AMUX        8'h2c
`define IOP_OFS_PORT_WIDE   8'h30
`define IOP_OFS_CTL         8'h34
`define IOP_OFS_LCD_ROLE    8'h38
`define IOP_OFS_LCD_EN      8'h3c
`define IOP_OFS_SIO_REF     8'h40
`define IOP_OFS_SIO_CFG     8'h44
`define IOP_OFS_SIO_HYST    8'h48
`define IOP_OFS_OUT_SEL0    8'h4c
`define IOP_OFS_OUT_SEL1    8'h50
`define IOP_OFS_OE_SEL0     8'h54
`define IOP_OFS_OE_SEL1     8'h58
`define IOP_OFS_DBL_SYNC    8'h5c
`define IOP_OFS_SYNC_OUT    8'h60
`define IOP_OFS_IRQ_STAT    8'h64
`define IOP_OFS_SNAP        8'h68
`define IOP_OFS_DR_WIN      8'h6c
`define IOP_OFS_PS_WIN      8'h70
`define IOP_OFS_PIN_CFG0    8'h80
`define IOP_OFS_IRQ_TYPE0   8'ha0
`define IOP_CFG_ZERO        8'h00
`define IOP_RESET_SYNC_N    2
`endif

// File: tb/test_iop_port.sv
// Self-checking testbench for the I/O port block.
// Assumes the block's own assertions are compiled with it and a 25 MHz clock.
`timescale 1ns/1ps
`include "iop_regs.svh"

module test_iop_port
   import iop_pkg::*;
;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
   logic [7:0]  adr_i, pin_i, dsi_in_o, slew_o, lcd_role_o, lcd_en_o, sio_ref_o, sio_cfg_o, sio_hyst_o;
   logic [3:0]  sel_i, port_ctl_o;
   logic [31:0] dat_i, dat_o, v;
   logic [23:0] drive_mode_o, dm_exp;
   logic [7:0]  dsi_out_i [4];
   logic [7:0]  dsi_oe_i [4];
   iop_pad_t    pad_o;
   int          error_cnt, num_checks;

   iop_port dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pin_i(pin_i), .dsi_out_i(dsi_out_i),
      .dsi_oe_i(dsi_oe_i), .dsi_in_o(dsi_in_o), .pad_o(pad_o), .drive_mode_o(drive_mode_o), .slew_o(slew_o),
      .port_ctl_o(port_ctl_o), .lcd_role_o(lcd_role_o), .lcd_en_o(lcd_en_o), .sio_ref_o(sio_ref_o),
      .sio_cfg_o(sio_cfg_o), .sio_hyst_o(sio_hyst_o), .irq_o(irq_o));

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   task automatic summarize();
      if (error_cnt == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= wr;
      adr_i <= a;
      dat_i <= d;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1) begin
         error_cnt++;
         $display("Error at %0t: bus wait timed out", $time);
         summarize();
      end
      q = dat_o;
      @(posedge clk_i);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb(1'b1, a, {24'h0, d}, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      wb(1'b0, a, 32'h0, q);
   endtask

   task automatic pin_set(input logic [7:0] p);
      @(posedge clk_i);
      pin_i <= p;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   task automatic t_data_path();
      wr(`IOP_OFS_OUT_DATA, 8'ha5);
      chk(32'(pad_o.out), 32'ha5);
      pin_set(8'h3c);
      rd(`IOP_OFS_PIN_LEVEL, v);
      chk(v, 32'h3c);
      wr(`IOP_OFS_BYPASS, 8'hff);
      for (int s = 0; s < 4; s++) begin
         wr(`IOP_OFS_OUT_SEL0, s[0] ? 8'hff : 8'h00);
         wr(`IOP_OFS_OUT_SEL1, s[1] ? 8'hff : 8'h00);
         chk(32'(pad_o.out), 32'(dsi_out_i[s]));
      end
      wr(`IOP_OFS_BYPASS, 8'h0f);
      chk(32'(pad_o.out), {24'h0, 8'ha0 | (dsi_out_i[3] & 8'h0f)});
      wr(`IOP_OFS_OUT_DATA, 8'h55);
      wr(`IOP_OFS_SYNC_OUT, 8'hff);
      @(negedge clk_i);
      chk(32'(pad_o.out), {24'h0, 8'h50 | (dsi_out_i[3] & 8'h0f)});
      rd(`IOP_OFS_OUT_DATA, v);
      chk(v, {24'h0, 8'h50 | (dsi_out_i[3] & 8'h0f)});
      wr(`IOP_OFS_SYNC_OUT, 8'h00);
      wr(`IOP_OFS_BYPASS, 8'h00);
   endtask

   task automatic t_windows();
      wr(`IOP_OFS_OUT_DATA, 8'h00);
      wr(`IOP_OFS_MASK, 8'h0f);
      wr(`IOP_OFS_DR_WIN, 8'hff);
      rd(`IOP_OFS_OUT_DATA, v);
      chk(v, 32'h0f);
      wr(`IOP_OFS_OUT_DATA, 8'h96);
      rd(`IOP_OFS_DR_WIN, v);
      chk(v, 32'h06);
      pin_set(8'h5b);
      rd(`IOP_OFS_PS_WIN, v);
      chk(v, 32'h0b);
      rd(8'h7c, v);
      chk(v, 32'h0);
   endtask

   task automatic t_modes();
      wr(`IOP_OFS_DM0, 8'h01);
      wr(`IOP_OFS_DM1, 8'h02);
      wr(`IOP_OFS_DM2, 8'h04);
      dm_exp = 24'h000111;
      chk(32'(drive_mode_o), 32'(dm_exp));
      chk(32'(pad_o.oe), 32'h06);
      chk(32'(pad_o.inp_en), 32'h07);
      wr(`IOP_OFS_INP_OFF, 8'h01);
      chk(32'(pad_o.inp_en), 32'h06);
      wr(`IOP_OFS_BIDIR, 8'hff);
      wr(`IOP_OFS_OE_SEL1, 8'hff);
      chk(32'(pad_o.oe), 32'(dsi_oe_i[2]));
      wr(`IOP_OFS_PORT_WIDE, 8'h00);
      wb(1'b1, `IOP_OFS_PORT_WIDE, 32'h00000600, v);
      rd(`IOP_OFS_INP_OFF, v);
      chk(v, 32'h00);
      wr(`IOP_OFS_PIN_CFG0 + 8'h0c, 8'h01);
      rd(`IOP_OFS_OUT_DATA, v);
      chk(v, 32'h08);
      rd(`IOP_OFS_PIN_CFG0 + 8'h0c, v);
      chk(32'(v[7]), 32'(pin_i[3]));
   endtask

   task automatic t_misc();
      wr(`IOP_OFS_AG, 8'h81);
      wr(`IOP_OFS_AMUX, 8'h42);
      chk({16'h0, pad_o.ag, pad_o.amux}, 32'h8142);
      wr(`IOP_OFS_CTL, 8'h0d);
      chk(32'(port_ctl_o), 32'hd);
      wr(`IOP_OFS_LCD_ROLE, 8'h33);
      wr(`IOP_OFS_LCD_EN, 8'hc4);
      chk({16'h0, lcd_role_o, lcd_en_o}, 32'h33c4);
      wr(`IOP_OFS_SIO_REF, 8'h1b);
      chk(32'(sio_ref_o), 32'h1b);
      wr(`IOP_OFS_SIO_CFG, 8'he4);
      chk(32'(sio_cfg_o), 32'he4);
      wr(`IOP_OFS_SIO_HYST, 8'h5a);
      chk(32'(sio_hyst_o), 32'h5a);
      wb(1'b1, `IOP_OFS_PORT_WIDE, 32'h00000700, v);
      chk(32'(slew_o), 32'hff);
   endtask

   task automatic t_sync();
      wr(`IOP_OFS_DBL_SYNC, 8'hff);
      pin_set(8'h00);
      repeat (3) @(posedge clk_i);
      pin_set(8'h69);
      @(negedge clk_i);
      @(negedge clk_i);
      chk(32'(dsi_in_o), 32'h00);
      @(negedge clk_i);
      chk(32'(dsi_in_o), 32'h69);
      wr(`IOP_OFS_DBL_SYNC, 8'h00);
      pin_set(8'h96);
      @(negedge clk_i);
      chk(32'(dsi_in_o), 32'h96);
   endtask

   task automatic t_irq();
      pin_set(8'h00);
      wr(`IOP_OFS_IRQ_TYPE0, 8'(IOP_IRQ_RISE));
      wr(`IOP_OFS_IRQ_TYPE0 + 8'h04, 8'(IOP_IRQ_FALL));
      wr(`IOP_OFS_IRQ_TYPE0 + 8'h08, 8'(IOP_IRQ_BOTH));
      pin_set(8'h0f);
      repeat (3) @(posedge clk_i);
      chk(32'(irq_o), 32'h1);
      rd(`IOP_OFS_IRQ_STAT, v);
      chk(v, 32'h05);
      rd(`IOP_OFS_SNAP, v);
      chk(v, 32'h0f);
      rd(`IOP_OFS_IRQ_STAT, v);
      chk(v, 32'h00);
      chk(32'(irq_o), 32'h0);
      pin_set(8'h00);
      repeat (3) @(posedge clk_i);
      rd(`IOP_OFS_IRQ_STAT, v);
      chk(v, 32'h06);
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      error_cnt = 0;
      num_checks = 0;
      rst_i = 1'b1;
      {cyc_i, stb_i, we_i} = 3'h0;
      adr_i = 8'h00;
      sel_i = 4'hf;
      dat_i = 32'h0;
      pin_i = 8'h00;
      dsi_out_i = '{8'h11, 8'h22, 8'h44, 8'h88};
      dsi_oe_i = '{8'hf0, 8'h0f, 8'hcc, 8'h33};
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({pad_o.out, pad_o.oe, pad_o.inp_en, irq_o, 7'h0}, 32'h0);
      t_data_path();
      t_windows();
      t_modes();
      t_misc();
      t_sync();
      t_irq();
      summarize();
   end
endmodule // test_iop_port
